// ### verilog/floor_cvt_regs.vh
// Register map, field positions and encodings of the floor-to-fixed converter
`ifndef FLOOR_CVT_REGS_VH
`define FLOOR_CVT_REGS_VH

// ****************************************************
// Register byte offsets
// ****************************************************
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_INSTR 8'h08
`define REG_FPR_SEL 8'h0c
`define REG_FPR_LO 8'h10
`define REG_FPR_HI 8'h14

// ****************************************************
// Control bits
// ****************************************************
`define CTRL_INV_ENABLE 0
`define CTRL_IEEE2008_NAN_MODE_BIT 1
`define CTRL_FR 2
`define CTRL_FPU64 3
`define CTRL_COP_USABLE 4
`define CTRL_RESET 32'h0000_0018

// ****************************************************
// Status bits (flags write-one-to-clear)
// ****************************************************
`define ST_INVALID 0
`define ST_INEXACT 1
`define ST_UNIMPL 2
`define ST_DONE 3
`define ST_EXC_INVALID 8
`define ST_EXC_COP 9
`define ST_EXC_RESERVED 10
`define ST_EXC_UNIMPL 11

// ****************************************************
// Instruction encoding
// ****************************************************
`define OP_MAJOR 6'h15
`define OP_MINOR_LONG 8'h0c
`define OP_MINOR_WORD 8'h2c
`define OP_FUNC 6'h3b

// ****************************************************
// Exception codes
// ****************************************************
`define EXC_NONE 3'h0
`define EXC_COP 3'h1
`define EXC_RESERVED 3'h2
`define EXC_UNIMPL 3'h3
`define EXC_INVALID 3'h4

// ****************************************************
// Default results
// ****************************************************
`define MAX_LONG 64'h7fff_ffff_ffff_ffff
`define MIN_LONG 64'h8000_0000_0000_0000
`define MAX_WORD 64'h0000_0000_7fff_ffff
`define MIN_WORD 64'h0000_0000_8000_0000

`endif

// ### verilog/floor_convert.v
// Combinational floor conversion of a single or double value to fixed point
`timescale 1ns/1ps
`include "floor_cvt_regs.vh"

module floor_convert (
    input wire [63:0] operand, // Raw source register contents
    input wire dbl,            // Source is double precision
    input wire to_long,        // Destination is 64-bit
    input wire ieee2008_nan_mode_bit,        // 2008 NaN mode
    output reg [63:0] result,  // Converted or default value
    output reg invalid,        // Invalid-operation condition
    output reg inexact         // Fraction discarded
);
    reg sign;
    reg special;
    reg nanv;
    reg [52:0] mant;
    reg signed [12:0] e;
    reg [5:0] sh;
    reg [63:0] mag;
    reg frac;
    reg [64:0] rmag;
    reg over;
    reg [63:0] conv;

    always @* begin
        if (dbl) begin
            sign = operand[63];
            special = &operand[62:52];
            nanv = special && (|operand[51:0]);
            mant = {(|operand[62:52]), operand[51:0]};
            if (operand[62:52] == 11'h000) begin
                e = -13'sd1022;
            end else begin
                e = $signed({2'b00, operand[62:52]}) - 13'sd1023;
            end
        end else begin
            sign = operand[31];
            special = &operand[30:23];
            nanv = special && (|operand[22:0]);
            mant = {(|operand[30:23]), operand[22:0], 29'h0};
            if (operand[30:23] == 8'h00) begin
                e = -13'sd126;
            end else begin
                e = $signed({5'b00000, operand[30:23]}) - 13'sd127;
            end
        end
        sh = e[5:0];
        mag = 64'h0;
        frac = 1'b0;
        if (e < 13'sd0) begin
            frac = |mant;
        end else if (e <= 13'sd52) begin
            mag = {11'h000, mant} >> (6'd52 - sh);
            frac = |(mant << (sh + 6'd1));
        end else if (e <= 13'sd63) begin
            mag = {11'h000, mant} << (sh - 6'd52);
        end
        // Rounding toward minus infinity grows a negative magnitude
        rmag = {1'b0, mag} + {64'h0, sign & frac};
        if (to_long) begin
            over = sign ? (rmag > {1'b0, `MIN_LONG}) : (rmag > {1'b0, `MAX_LONG});
        end else begin
            over = sign ? (rmag > {1'b0, `MIN_WORD}) : (rmag > {1'b0, `MAX_WORD});
        end
        invalid = special || (e > 13'sd63) || over;
        inexact = frac && !invalid;
        conv = sign ? (~rmag[63:0] + 64'h1) : rmag[63:0];
        if (!invalid) begin
            result = to_long ? conv : {32'h0, conv[31:0]};
        end else if (!ieee2008_nan_mode_bit) begin
            result = `MAX_LONG;
        end else if (nanv) begin
            result = 64'h0;
        end else if (sign) begin
            result = to_long ? `MIN_LONG : `MIN_WORD;
        end else begin
            result = to_long ? `MAX_LONG : `MAX_WORD;
        end
    end
endmodule

// ### verilog/float_floor_to_fixed.v
// Floor-to-fixed execution unit with register file and AXI4-Lite access
`timescale 1ns/1ps
`include "floor_cvt_regs.vh"

module float_floor_to_fixed (
    input wire aclk,                 // Clock, 250 MHz
    input wire aresetn,              // Synchronous reset, active low
    input wire [7:0] s_axi_awaddr,   // Write address
    input wire s_axi_awvalid,        // Write address valid
    output wire s_axi_awready,       // Write address ready
    input wire [31:0] s_axi_wdata,   // Write data
    input wire [3:0] s_axi_wstrb,    // Write byte strobes
    input wire s_axi_wvalid,         // Write data valid
    output wire s_axi_wready,        // Write data ready
    output reg [1:0] s_axi_bresp,    // Write response
    output reg s_axi_bvalid,         // Write response valid
    input wire s_axi_bready,         // Write response ready
    input wire [7:0] s_axi_araddr,   // Read address
    input wire s_axi_arvalid,        // Read address valid
    output wire s_axi_arready,       // Read address ready
    output reg [31:0] s_axi_rdata,   // Read data
    output reg [1:0] s_axi_rresp,    // Read response
    output reg s_axi_rvalid,         // Read data valid
    input wire s_axi_rready,         // Read data ready
    output reg fp_exception,         // Exception taken, one-cycle pulse
    output reg [2:0] fp_exception_code // Cause of the last exception
);
    localparam RESP_OKAY = 2'b00;
    localparam RESP_SLVERR = 2'b10;

    // ****************************************************
    // Functions
    // ****************************************************
    function [31:0] merge_bytes;
        input [31:0] old_val;
        input [31:0] new_val;
        input [3:0] strb;
        integer i;
        begin
            merge_bytes = old_val;
            for (i = 0; i < 4; i = i + 1) begin
                if (strb[i]) begin
                    merge_bytes[i*8 +: 8] = new_val[i*8 +: 8];
                end
            end
        end
    endfunction

    function mapped;
        input [7:0] addr;
        begin
            mapped = (addr == `REG_CTRL) || (addr == `REG_STATUS) ||
                     (addr == `REG_INSTR) || (addr == `REG_FPR_SEL) ||
                     (addr == `REG_FPR_LO) || (addr == `REG_FPR_HI);
        end
    endfunction

    // ****************************************************
    // State
    // ****************************************************
    reg [31:0] ctrl;
    reg [31:0] status;
    reg [31:0] instr;
    reg [4:0] fpr_sel;
    reg [63:0] fpr [0:31];
    reg exec_pending;
    reg aw_full;
    reg w_full;
    reg [7:0] aw_addr;
    reg [31:0] w_data;
    reg [3:0] w_strb;
    reg [31:0] next_status_set;
    reg [31:0] status_clr;
    reg wr_fire;
    reg [31:0] read_mux;
    integer k;

    // ****************************************************
    // Decode
    // ****************************************************
    wire [4:0] dst_field = instr[25:21];
    wire [4:0] src_field = instr[20:16];
    wire fmt_dbl = instr[14];
    wire codes_ok = (instr[31:26] == `OP_MAJOR) && (instr[5:0] == `OP_FUNC) &&
                    !instr[15];
    wire is_long = codes_ok && (instr[13:6] == `OP_MINOR_LONG);
    wire is_word = codes_ok && (instr[13:6] == `OP_MINOR_WORD);

    wire [63:0] cvt_result;
    wire cvt_invalid;
    wire cvt_inexact;

    floor_convert u_floor_convert (
        .operand(fpr[src_field]),
        .dbl(fmt_dbl),
        .to_long(is_long),
        .ieee2008_nan_mode_bit(ctrl[`CTRL_IEEE2008_NAN_MODE_BIT]),
        .result(cvt_result),
        .invalid(cvt_invalid),
        .inexact(cvt_inexact)
    );

    // ****************************************************
    // Execution outcome
    // ****************************************************
    reg do_write;
    reg [2:0] exc_code;

    always @* begin
        do_write = 1'b0;
        exc_code = `EXC_NONE;
        next_status_set = 32'h0;
        if (exec_pending) begin
            next_status_set[`ST_DONE] = 1'b1;
            if (!ctrl[`CTRL_COP_USABLE]) begin
                exc_code = `EXC_COP;
                next_status_set[`ST_EXC_COP] = 1'b1;
            end else if (!is_long && !is_word) begin
                exc_code = `EXC_RESERVED;
                next_status_set[`ST_EXC_RESERVED] = 1'b1;
            end else if (is_long && (!ctrl[`CTRL_FR] || !ctrl[`CTRL_FPU64])) begin
                exc_code = `EXC_UNIMPL;
                next_status_set[`ST_UNIMPL] = 1'b1;
                next_status_set[`ST_EXC_UNIMPL] = 1'b1;
            end else if (cvt_invalid) begin
                next_status_set[`ST_INVALID] = 1'b1;
                if (ctrl[`CTRL_INV_ENABLE]) begin
                    exc_code = `EXC_INVALID;
                    next_status_set[`ST_EXC_INVALID] = 1'b1;
                end else begin
                    do_write = 1'b1;
                end
            end else begin
                do_write = 1'b1;
                next_status_set[`ST_INEXACT] = cvt_inexact;
            end
        end
    end

    // ****************************************************
    // AXI4-Lite write channel
    // ****************************************************
    assign s_axi_awready = !aw_full && !s_axi_bvalid;
    assign s_axi_wready = !w_full && !s_axi_bvalid;

    always @* begin
        wr_fire = aw_full && w_full && !s_axi_bvalid;
        status_clr = 32'h0;
        if (wr_fire && (aw_addr == `REG_STATUS)) begin
            status_clr = merge_bytes(32'h0, w_data, w_strb);
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_full <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_full <= 1'b0;
                w_full <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ****************************************************
    // Registers and execution
    // ****************************************************
    always @(posedge aclk) begin
        if (!aresetn) begin
            ctrl <= `CTRL_RESET;
            status <= 32'h0;
            instr <= 32'h0;
            fpr_sel <= 5'h00;
            exec_pending <= 1'b0;
            fp_exception <= 1'b0;
            fp_exception_code <= `EXC_NONE;
            for (k = 0; k < 32; k = k + 1) begin
                fpr[k] <= 64'h0;
            end
        end else begin
            exec_pending <= wr_fire && (aw_addr == `REG_INSTR);
            // A flag raised in the same cycle as its clear stays set
            status <= (status & ~status_clr) | next_status_set;
            fp_exception <= (exc_code != `EXC_NONE);
            if (exc_code != `EXC_NONE) begin
                fp_exception_code <= exc_code;
            end
            if (do_write) begin
                fpr[dst_field] <= cvt_result;
            end
            if (wr_fire) begin
                case (aw_addr)
                    `REG_CTRL: begin
                        ctrl <= merge_bytes(ctrl, w_data, w_strb) & 32'h0000_001f;
                    end
                    `REG_INSTR: begin
                        instr <= merge_bytes(instr, w_data, w_strb);
                    end
                    `REG_FPR_SEL: begin
                        if (w_strb[0]) begin
                            fpr_sel <= w_data[4:0];
                        end
                    end
                    `REG_FPR_LO: begin
                        fpr[fpr_sel][31:0] <= merge_bytes(fpr[fpr_sel][31:0], w_data, w_strb);
                    end
                    `REG_FPR_HI: begin
                        fpr[fpr_sel][63:32] <= merge_bytes(fpr[fpr_sel][63:32], w_data,
                                                           w_strb);
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // ****************************************************
    // AXI4-Lite read channel
    // ****************************************************
    assign s_axi_arready = !s_axi_rvalid;

    always @* begin
        case (s_axi_araddr)
            `REG_CTRL: read_mux = ctrl;
            `REG_STATUS: read_mux = status;
            `REG_INSTR: read_mux = instr;
            `REG_FPR_SEL: read_mux = {27'h0, fpr_sel};
            `REG_FPR_LO: read_mux = fpr[fpr_sel][31:0];
            `REG_FPR_HI: read_mux = fpr[fpr_sel][63:32];
            default: read_mux = 32'h0;
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= read_mux;
                s_axi_rresp <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule

// ### sim/float_floor_checker.sv
// Concurrent checks on the floor-to-fixed unit's ports
`timescale 1ns/1ps
module float_floor_checker (
    input wire aclk, // Clock
    input wire aresetn, // Reset, active low
    input wire s_axi_awvalid, // Write address valid
    input wire s_axi_awready, // Write address ready
    input wire s_axi_wvalid, // Write data valid
    input wire s_axi_wready, // Write data ready
    input wire [1:0] s_axi_bresp, // Write response
    input wire s_axi_bvalid, // Write response valid
    input wire s_axi_bready, // Write response ready
    input wire s_axi_arvalid, // Read address valid
    input wire s_axi_arready, // Read address ready
    input wire [31:0] s_axi_rdata, // Read data
    input wire [1:0] s_axi_rresp, // Read response
    input wire s_axi_rvalid, // Read data valid
    input wire s_axi_rready, // Read data ready
    input wire fp_exception, // Exception pulse
    input wire [2:0] fp_exception_code // Exception cause
);
default clocking cb @(posedge aclk); endclocking
default disable iff (!aresetn);
sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
endsequence
sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
endsequence
a_write_answer: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write response missing");
a_read_answer: assert property (rd_taken |=> s_axi_rvalid)
    else $error("read data missing");
a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read data dropped");
a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted during response");
a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted during response");
a_exc_pulse: assert property (fp_exception |=> !fp_exception)
    else $error("exception longer than one cycle");
a_exc_after_cmd: assert property (fp_exception |-> $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
    else $error("exception without a command");
a_exc_code_valid: assert property (fp_exception |-> fp_exception_code inside {[3'h1:3'h4]})
    else $error("exception cause out of range");
a_code_hold: assert property ($changed(fp_exception_code) |-> fp_exception)
    else $error("exception cause changed alone");
endmodule

bind float_floor_to_fixed float_floor_checker u_float_floor_checker (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .fp_exception(fp_exception), .fp_exception_code(fp_exception_code));

// ### sim/lite_master.sv
// Register bus master standing in for the issuing software
`timescale 1ns/1ps
module lite_master (
    input wire aclk, // Clock
    output logic [7:0] s_axi_awaddr, // Write address
    output logic s_axi_awvalid, // Write address valid
    input wire s_axi_awready, // Write address ready
    output logic [31:0] s_axi_wdata, // Write data
    output logic [3:0] s_axi_wstrb, // Byte strobes
    output logic s_axi_wvalid, // Write data valid
    input wire s_axi_wready, // Write data ready
    input wire [1:0] s_axi_bresp, // Write response
    input wire s_axi_bvalid, // Write response valid
    output logic s_axi_bready, // Write response ready
    output logic [7:0] s_axi_araddr, // Read address
    output logic s_axi_arvalid, // Read address valid
    input wire s_axi_arready, // Read address ready
    input wire [31:0] s_axi_rdata, // Read data
    input wire [1:0] s_axi_rresp, // Read response
    input wire s_axi_rvalid, // Read data valid
    output logic s_axi_rready // Read data ready
);
initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
end
// Released payload is inverted so stale values never look valid
task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw;
    logic w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw && w)) begin
        @(posedge aclk);
        if (s_axi_awvalid && s_axi_awready) begin
            aw = 1'b1;
            s_axi_awvalid <= 1'b0;
            s_axi_awaddr <= ~a;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w = 1'b1;
            s_axi_wvalid <= 1'b0;
            s_axi_wdata <= ~d;
        end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
endtask
task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
        @(posedge aclk);
        if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arvalid <= 1'b0;
            s_axi_araddr <= ~a;
        end
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
endtask
endmodule

// ### sim/tb_float_floor_to_fixed.sv
// Self-checking bench of the floor-to-fixed unit
`timescale 1ns/1ps
`include "floor_cvt_regs.vh"
module tb_float_floor_to_fixed;
// ****************************************************
// Clock, reset and instances
// ****************************************************
logic aclk = 1'b0;
logic aresetn = 1'b0;
wire [7:0] s_axi_awaddr, s_axi_araddr;
wire [31:0] s_axi_wdata, s_axi_rdata;
wire [3:0] s_axi_wstrb;
wire [1:0] s_axi_bresp, s_axi_rresp;
wire [2:0] fp_exception_code;
wire s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
wire s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, fp_exception;
int miscompares = 0;
int checked = 0;
int exc_seen = 0;
always #2 aclk = ~aclk;
always @(posedge aclk) if (fp_exception === 1'b1) exc_seen <= exc_seen + 1;
float_floor_to_fixed u_float_floor_to_fixed (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .fp_exception(fp_exception),
    .fp_exception_code(fp_exception_code));
lite_master u_lite_master (.aclk(aclk),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
// ****************************************************
// Helpers
// ****************************************************
typedef struct packed {
    logic [7:0] minor; logic fmt; logic [5:0] func; logic [7:0] ctrl;
    logic [63:0] op; logic [63:0] res; logic [11:0] st; logic [2:0] code;
} row_t;
localparam logic [7:0] LG = `OP_MINOR_LONG;
localparam logic [7:0] WD = `OP_MINOR_WORD;
localparam logic [5:0] FN = `OP_FUNC;
localparam logic [63:0] PAT = 64'ha5a5a5a5_5a5a5a5a;
row_t rows [19];
logic [2:0] last_code = 3'h0;
task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
        miscompares++;
        $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
endtask
task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    u_lite_master.wr(a, d, r);
    chk(r, 2'b00);
endtask
task automatic rd(input logic [7:0] a, output logic [31:0] d);
    logic [1:0] r;
    u_lite_master.rd(a, d, r);
    chk(r, 2'b00);
endtask
task automatic run(input row_t r, input logic [4:0] dst, input logic [4:0] src);
    logic [31:0] lo;
    logic [31:0] hi;
    int e0;
    wr(`REG_CTRL, {24'h0, r.ctrl});
    wr(`REG_FPR_SEL, {27'h0, dst});
    wr(`REG_FPR_LO, PAT[31:0]);
    wr(`REG_FPR_HI, PAT[63:32]);
    wr(`REG_FPR_SEL, {27'h0, src});
    wr(`REG_FPR_LO, r.op[31:0]);
    wr(`REG_FPR_HI, r.op[63:32]);
    wr(`REG_STATUS, 32'h0000_0fff);
    e0 = exc_seen;
    wr(`REG_INSTR, {`OP_MAJOR, dst, src, 1'b0, r.fmt, r.minor, r.func});
    rd(`REG_STATUS, lo);
    chk(64'(lo[11:0] & 12'hf07), 64'(r.st));
    wr(`REG_FPR_SEL, {27'h0, dst});
    rd(`REG_FPR_LO, lo);
    rd(`REG_FPR_HI, hi);
    chk({hi, lo}, r.res);
    chk(64'(exc_seen - e0), 64'(r.code != 3'h0));
    if (r.code != 3'h0) last_code = r.code;
    chk(64'(fp_exception_code), 64'(last_code));
endtask
task automatic results();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
endtask
// ****************************************************
// Tests
// ****************************************************
initial begin
    repeat (20000) @(posedge aclk);
    miscompares++;
    results();
end
initial begin
    logic [31:0] v;
    logic [1:0] rs;
    // Operands are well-formed and name valid registers
    rows = '{
        '{LG, 1'b0, FN, 8'h1c, 64'h4020_0000, 64'h2, 12'h002, 3'h0},
        '{LG, 1'b0, FN, 8'h1c, 64'hc020_0000, 64'hffff_ffff_ffff_fffd, 12'h002, 3'h0},
        '{WD, 1'b1, FN, 8'h1c, 64'hbff8_0000_0000_0000, 64'hffff_fffe, 12'h002, 3'h0},
        '{WD, 1'b1, FN, 8'h1c, 64'h401c_0000_0000_0000, 64'h7, 12'h000, 3'h0},
        '{WD, 1'b0, FN, 8'h1e, 64'h7f80_0000, `MAX_WORD, 12'h001, 3'h0},
        '{WD, 1'b0, FN, 8'h1e, 64'hff80_0000, `MIN_WORD, 12'h001, 3'h0},
        '{LG, 1'b1, FN, 8'h1e, 64'h7ff8_0000_0000_0000, 64'h0, 12'h001, 3'h0},
        '{WD, 1'b0, FN, 8'h1c, 64'h7fc0_0000, `MAX_LONG, 12'h001, 3'h0},
        '{WD, 1'b0, FN, 8'h1e, 64'h4f00_0000, `MAX_WORD, 12'h001, 3'h0},
        '{WD, 1'b0, FN, 8'h1e, 64'hcf00_0000, `MIN_WORD, 12'h000, 3'h0},
        '{LG, 1'b0, FN, 8'h1c, 64'hbf00_0000, 64'hffff_ffff_ffff_ffff, 12'h002, 3'h0},
        '{LG, 1'b0, FN, 8'h1c, 64'h3f00_0000, 64'h0, 12'h002, 3'h0},
        '{WD, 1'b0, FN, 8'h1d, 64'h7f80_0000, PAT, 12'h101, `EXC_INVALID},
        '{WD, 1'b0, FN, 8'h0c, 64'h3f80_0000, PAT, 12'h200, `EXC_COP},
        '{WD, 1'b0, 6'h3a, 8'h1c, 64'h3f80_0000, PAT, 12'h400, `EXC_RESERVED},
        '{LG, 1'b0, FN, 8'h18, 64'h3f80_0000, PAT, 12'h804, `EXC_UNIMPL},
        '{LG, 1'b1, FN, 8'h1e, 64'hfff0_0000_0000_0000, `MIN_LONG, 12'h001, 3'h0},
        '{LG, 1'b1, FN, 8'h1e, 64'h43e0_0000_0000_0000, `MAX_LONG, 12'h001, 3'h0},
        '{LG, 1'b1, FN, 8'h1c, 64'hc3e0_0000_0000_0000, `MIN_LONG, 12'h000, 3'h0}
    };
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`REG_CTRL, v);
    chk(v, `CTRL_RESET);
    rd(`REG_STATUS, v);
    chk(v, 32'h0);
    foreach (rows[i]) run(rows[i], 5'(i + 1), 5'(30 - i));
    // Unmapped place: error response, write ignored, read as zero
    u_lite_master.wr(8'h40, 32'h1, rs);
    chk(rs, 2'b10);
    u_lite_master.rd(8'h40, v, rs);
    chk({rs, v}, {2'b10, 32'h0});
    // Second reset in mid-run restores control, status and cause
    wr(`REG_CTRL, 32'h0000_0007);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`REG_CTRL, v);
    chk(v, `CTRL_RESET);
    chk(fp_exception_code, 3'h0);
    rd(`REG_STATUS, v);
    chk(v, 32'h0);
    results();
end
endmodule
